// file: rtl/dll_pkg.sv
package dll_pkg;

   // register bus
   localparam int          APB_AW        = 8;
   localparam int          APB_DW        = 32;
   localparam logic [7:0]  CTRL_OFS      = 8'h00;
   localparam logic [7:0]  STATUS_OFS    = 8'h04;
   localparam logic [7:0]  CODE_OFS      = 8'h08;
   localparam logic [7:0]  USER_CODE_OFS = 8'h0C;
   localparam logic [7:0]  IRQ_STAT_OFS  = 8'h10;
   localparam logic [7:0]  IRQ_MASK_OFS  = 8'h14;

   // control fields
   localparam int          CTRL_W            = 6;
   localparam int          CTRL_SRST_BIT     = 0;
   localparam int          CTRL_REFSEL_BIT   = 1;
   localparam int          CTRL_STB_SEL_BIT  = 4;
   localparam int          CTRL_CLK_SEL_BIT  = 5;
   localparam logic [5:0]  CTRL_RST          = 6'h00;

   // status fields
   localparam int          STATUS_LOCK_BIT   = 0;
   localparam int          STATUS_FROZEN_BIT = 8;

   // loop geometry
   localparam int          MAX_LOOPS         = 2;
   localparam int          NUM_LOOPS_DEF     = 2;
   localparam int          CODE_W_DEF        = 8;
   localparam int          CNT_W_DEF         = 12;
   localparam int          LOCK_MATCHES_DEF  = 4;
   localparam int          LOCK_TOL          = 1;
   localparam int          MATCH_W           = 4;

   // fixed latency of sync + history + output register in the slave lines
   localparam int          LINE_LATENCY      = 4;

endpackage

// file: rtl/dly_if.sv
`timescale 1ns/1ps
interface dly_if #(
   parameter int CODE_W = 8
);
   logic              sigIn;
   logic [CODE_W-1:0] code;
   logic              sigOut;

   modport src (
      output sigIn,
      output code,
      input  sigOut
   );

   modport line (
      input  sigIn,
      input  code,
      output sigOut
   );
endinterface

// file: rtl/tap_delay_line.sv
`timescale 1ns/1ps
module tap_delay_line
   import dll_pkg::*;
#(
   parameter int CODE_W = CODE_W_DEF
) (
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic ce,
   dly_if.line      dl
);
   localparam int DEPTH = 2 ** CODE_W;

   logic [DEPTH-1:0] history_ff;
   logic             out_ff;
   wire  [DEPTH-1:0] nxt_history = {history_ff[DEPTH-2:0], dl.sigIn};
   wire              nxt_out     = history_ff[dl.code];

   // tapped history; output delay is code + fixed latency
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         history_ff <= '0;
         out_ff     <= 1'b0;
      end else if (ce) begin
         history_ff <= nxt_history;
         out_ff     <= nxt_out;
      end
   end

   assign dl.sigOut = out_ff;
endmodule

// file: rtl/master_dll_delay_code_gen.sv
// The implementer's own choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
module master_dll_delay_code_gen
   import dll_pkg::*;
#(
   parameter int NUM_LOOPS    = NUM_LOOPS_DEF,
   parameter int CODE_W       = CODE_W_DEF,
   parameter int CNT_W        = CNT_W_DEF,
   parameter int LOCK_MATCHES = LOCK_MATCHES_DEF
) (
   input  wire logic                               sys_clk,
   input  wire logic                               arst_n,
   input  wire logic                               ce,
   input  wire logic [NUM_LOOPS-1:0]               pllRefClk,
   input  wire logic [NUM_LOOPS-1:0]               pinRefClk,
   input  wire logic                               freeze,
   input  wire logic                               codeUpdate_n,
   input  wire logic                               strobeIn,
   input  wire logic                               clkIn,
   output wire logic                               strobeShifted,
   output wire logic                               clkShifted,
   output wire logic [NUM_LOOPS-1:0][CODE_W-1:0]   slaveDelayCode,
   output wire logic [NUM_LOOPS-1:0][CODE_W-1:0]   userDelayCode,
   output wire logic [NUM_LOOPS-1:0]               lock,
   output wire logic                               irq,
   input  wire logic [APB_AW-1:0]                  paddr,
   input  wire logic                               psel,
   input  wire logic                               penable,
   input  wire logic                               pwrite,
   input  wire logic [APB_DW-1:0]                  pwdata,
   input  wire logic [3:0]                         pstrb,
   output wire logic [APB_DW-1:0]                  prdata,
   output wire logic                               pready,
   output wire logic                               pslverr
);
   localparam int IRQ_W = 2 * NUM_LOOPS;

   if (NUM_LOOPS < 1 || NUM_LOOPS > MAX_LOOPS || CODE_W < 3 || CODE_W > 10 ||
       CNT_W < CODE_W + 2 || CNT_W > 24 || LOCK_MATCHES < 1 || LOCK_MATCHES > 15) begin : g_bad_params
      $error("master_dll_delay_code_gen: unsupported parameter values");
   end

   // rounded quarter of a period count, saturated to the code range
   function automatic logic [CODE_W-1:0] quarterCode(input logic [CNT_W-1:0] p);
      logic [CNT_W:0] q;
      q = ({1'b0, p} + (CNT_W+1)'(2)) >> 2;
      if (q > (CNT_W+1)'((2 ** CODE_W) - 1)) begin
         quarterCode = '1;
      end else begin
         quarterCode = q[CODE_W-1:0];
      end
   endfunction

   function automatic logic codeNear(input logic [CODE_W-1:0] a, input logic [CODE_W-1:0] b);
      logic [CODE_W-1:0] d;
      d = (a > b) ? a - b : b - a;
      codeNear = (d <= CODE_W'(LOCK_TOL));
   endfunction

   // remove the fixed slave line latency from the tap index
   function automatic logic [CODE_W-1:0] tapFor(input logic [CODE_W-1:0] c);
      tapFor = (c > CODE_W'(LINE_LATENCY)) ? c - CODE_W'(LINE_LATENCY) : '0;
   endfunction

   // ---------------- register bus ----------------
   logic [CTRL_W-1:0]  ctrl_ff;
   logic [IRQ_W-1:0]   irqStat_ff;
   logic [IRQ_W-1:0]   irqMask_ff;
   logic [APB_DW-1:0]  prdata_ff;
   logic               freeze_ff;

   wire [NUM_LOOPS-1:0]             lockVec;
   wire [NUM_LOOPS-1:0]             lockGain;
   wire [NUM_LOOPS-1:0]             lockLoss;
   wire [NUM_LOOPS-1:0][CODE_W-1:0] codeVec;
   wire [NUM_LOOPS-1:0][CODE_W-1:0] userVec;

   wire              apbSetup   = psel & ~penable;
   wire              apbAccess  = psel & penable;
   wire              apbWrite   = apbAccess & pwrite & pstrb[0];
   wire              hitCtrl    = (paddr == CTRL_OFS);
   wire              hitStatus  = (paddr == STATUS_OFS);
   wire              hitCode    = (paddr == CODE_OFS);
   wire              hitUser    = (paddr == USER_CODE_OFS);
   wire              hitStat    = (paddr == IRQ_STAT_OFS);
   wire              hitMask    = (paddr == IRQ_MASK_OFS);
   wire              addrHit    = hitCtrl | hitStatus | hitCode | hitUser | hitStat | hitMask;
   wire              wrCtrl     = apbWrite & hitCtrl;
   wire              wrStat     = apbWrite & hitStat;
   wire              wrMask     = apbWrite & hitMask;

   wire [APB_DW-1:0] statusWord = (APB_DW'(lockVec) << STATUS_LOCK_BIT) |
                                  (APB_DW'(freeze_ff) << STATUS_FROZEN_BIT);
   wire [APB_DW-1:0] readWord   = hitCtrl   ? APB_DW'(ctrl_ff)    :
                                  hitStatus ? statusWord          :
                                  hitCode   ? APB_DW'(codeVec)    :
                                  hitUser   ? APB_DW'(userVec)    :
                                  hitStat   ? APB_DW'(irqStat_ff) :
                                  hitMask   ? APB_DW'(irqMask_ff) :
                                              32'h0000_0000;

   wire [CTRL_W-1:0] nxt_ctrl    = wrCtrl ? pwdata[CTRL_W-1:0] : ctrl_ff;
   wire [IRQ_W-1:0]  irqClr      = wrStat ? pwdata[IRQ_W-1:0] : '0;
   // a new event wins over a clear in the same cycle
   wire [IRQ_W-1:0]  nxt_irqStat = (irqStat_ff & ~irqClr) | {lockLoss, lockGain};
   wire [IRQ_W-1:0]  nxt_irqMask = wrMask ? pwdata[IRQ_W-1:0] : irqMask_ff;
   wire [APB_DW-1:0] nxt_prdata  = apbSetup ? readWord : prdata_ff;

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         ctrl_ff    <= CTRL_RST;
         irqStat_ff <= '0;
         irqMask_ff <= '0;
         prdata_ff  <= 32'h0000_0000;
      end else if (ce) begin
         ctrl_ff    <= nxt_ctrl;
         irqStat_ff <= nxt_irqStat;
         irqMask_ff <= nxt_irqMask;
         prdata_ff  <= nxt_prdata;
      end
   end

   assign pready  = 1'b1;
   assign pslverr = apbAccess & ~addrHit;
   assign prdata  = prdata_ff;
   assign irq     = |(irqStat_ff & irqMask_ff);

   // ---------------- freeze ----------------
   // registered so the stop and restart take effect on a clock edge only
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         freeze_ff <= 1'b0;
      end else if (ce) begin
         freeze_ff <= freeze;
      end
   end

   wire softRst = ctrl_ff[CTRL_SRST_BIT];

   // ---------------- master loops ----------------
   for (genvar i = 0; i < NUM_LOOPS; i++) begin : g_loop
      logic              refSync1_ff;
      logic              refSync2_ff;
      logic              refPrev_ff;
      logic [CNT_W-1:0]  periodCnt_ff;
      logic              seenEdge_ff;
      logic [CODE_W-1:0] code_ff;
      logic [MATCH_W-1:0] matchCnt_ff;
      logic              lock_ff;
      logic              lockDly_ff;
      logic [CODE_W-1:0] userCode_ff;

      wire              refRaw   = ctrl_ff[CTRL_REFSEL_BIT+i] ? pinRefClk[i] : pllRefClk[i];
      wire              refRise  = refSync2_ff & ~refPrev_ff;
      wire              cntFull  = &periodCnt_ff;
      wire [CODE_W-1:0] newCode  = quarterCode(periodCnt_ff);
      wire              codeHit  = codeNear(newCode, code_ff);
      wire              matchEnd = (matchCnt_ff >= MATCH_W'(LOCK_MATCHES - 1));

      always_ff @(posedge sys_clk or negedge arst_n) begin
         if (!arst_n) begin
            refSync1_ff <= 1'b0;
            refSync2_ff <= 1'b0;
         end else if (ce) begin
            refSync1_ff <= refRaw;
            refSync2_ff <= refSync1_ff;
         end
      end

      always_ff @(posedge sys_clk or negedge arst_n) begin
         if (!arst_n) begin
            refPrev_ff   <= 1'b0;
            periodCnt_ff <= '0;
            seenEdge_ff  <= 1'b0;
            code_ff      <= '0;
            matchCnt_ff  <= '0;
            lock_ff      <= 1'b0;
         end else if (ce) begin
            refPrev_ff <= refSync2_ff;
            if (softRst) begin
               periodCnt_ff <= '0;
               seenEdge_ff  <= 1'b0;
               code_ff      <= '0;
               matchCnt_ff  <= '0;
               lock_ff      <= 1'b0;
            end else if (freeze_ff) begin
               // code and lock held; the partial period is discarded
               seenEdge_ff <= 1'b0;
            end else if (refRise) begin
               periodCnt_ff <= CNT_W'(1);
               seenEdge_ff  <= 1'b1;
               if (seenEdge_ff) begin
                  code_ff <= newCode;
                  if (codeHit) begin
                     matchCnt_ff <= matchEnd ? matchCnt_ff : matchCnt_ff + MATCH_W'(1);
                     lock_ff     <= lock_ff | matchEnd;
                  end else begin
                     matchCnt_ff <= '0;
                     lock_ff     <= 1'b0;
                  end
               end
            end else if (cntFull) begin
               // reference lost or too slow: code no longer valid
               seenEdge_ff <= 1'b0;
               matchCnt_ff <= '0;
               lock_ff     <= 1'b0;
            end else begin
               periodCnt_ff <= periodCnt_ff + CNT_W'(1);
            end
         end
      end

      always_ff @(posedge sys_clk or negedge arst_n) begin
         if (!arst_n) begin
            lockDly_ff  <= 1'b0;
            userCode_ff <= '0;
         end else if (ce) begin
            lockDly_ff <= lock_ff;
            if (softRst) begin
               userCode_ff <= '0;
            end else if (!codeUpdate_n) begin
               userCode_ff <= code_ff;
            end
         end
      end

      assign lockVec[i]  = lock_ff;
      assign lockGain[i] = lock_ff & ~lockDly_ff;
      assign lockLoss[i] = ~lock_ff & lockDly_ff;
      assign codeVec[i]  = code_ff;
      assign userVec[i]  = userCode_ff;
   end

   assign slaveDelayCode = codeVec;
   assign userDelayCode  = userVec;
   assign lock           = lockVec;

   // ---------------- slave delay lines ----------------
   logic stbSync1_ff;
   logic stbSync2_ff;
   logic clkSync1_ff;
   logic clkSync2_ff;

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         stbSync1_ff <= 1'b0;
         stbSync2_ff <= 1'b0;
         clkSync1_ff <= 1'b0;
         clkSync2_ff <= 1'b0;
      end else if (ce) begin
         stbSync1_ff <= strobeIn;
         stbSync2_ff <= stbSync1_ff;
         clkSync1_ff <= clkIn;
         clkSync2_ff <= clkSync1_ff;
      end
   end

   wire stbIdx = ctrl_ff[CTRL_STB_SEL_BIT] & (NUM_LOOPS > 1);
   wire clkIdx = ctrl_ff[CTRL_CLK_SEL_BIT] & (NUM_LOOPS > 1);

   dly_if #(.CODE_W(CODE_W)) stbLine ();
   dly_if #(.CODE_W(CODE_W)) clkLine ();

   assign stbLine.sigIn = stbSync2_ff;
   assign stbLine.code  = tapFor(codeVec[stbIdx]);
   assign clkLine.sigIn = clkSync2_ff;
   assign clkLine.code  = tapFor(codeVec[clkIdx]);

   tap_delay_line #(
      .CODE_W (CODE_W)
   ) u_strobe_delay_buffer (
      .sys_clk (sys_clk),
      .arst_n  (arst_n),
      .ce      (ce),
      .dl      (stbLine)
   );

   tap_delay_line #(
      .CODE_W (CODE_W)
   ) u_clock_delay_slave (
      .sys_clk (sys_clk),
      .arst_n  (arst_n),
      .ce      (ce),
      .dl      (clkLine)
   );

   assign strobeShifted = stbLine.sigOut;
   assign clkShifted    = clkLine.sigOut;
endmodule

// file: verif/dll_code_checker.sv
`timescale 1ns/1ps
module dll_code_checker
   import dll_pkg::*;
#(
   parameter int NUM_LOOPS = NUM_LOOPS_DEF,
   parameter int CODE_W    = CODE_W_DEF
) (
   input wire logic                             sys_clk,
   input wire logic                             arst_n,
   input wire logic                             freeze,
   input wire logic                             codeUpdate_n,
   input wire logic [NUM_LOOPS-1:0][CODE_W-1:0] slaveDelayCode,
   input wire logic [NUM_LOOPS-1:0][CODE_W-1:0] userDelayCode,
   input wire logic [NUM_LOOPS-1:0]             lock,
   input wire logic                             irq,
   input wire logic [APB_AW-1:0]                paddr,
   input wire logic                             psel,
   input wire logic                             penable,
   input wire logic [APB_DW-1:0]                prdata,
   input wire logic                             pslverr
);
   default clocking @(posedge sys_clk);
   endclocking
   default disable iff (!arst_n);

   lock_after_reset_a: assert property ($rose(arst_n) |-> (lock == '0) [*8])
      else $error("lock set too soon after reset");
   reset_outputs_a: assert property ($rose(arst_n) |-> !irq && slaveDelayCode == '0 && userDelayCode == '0)
      else $error("outputs not cleared by reset");
   user_hold_a: assert property ($past(codeUpdate_n, 2) && $past(codeUpdate_n) |-> $stable(userDelayCode))
      else $error("user code moved while update high");
   freeze_hold_a: assert property ($past(freeze, 2) && $past(freeze) |-> $stable(slaveDelayCode) && $stable(lock))
      else $error("code or lock moved while frozen");
   lock_step_a: assert property (lock[0] && $past(lock[0]) |-> slaveDelayCode[0] <= $past(slaveDelayCode[0]) + 9'd1
      && $past(slaveDelayCode[0]) <= slaveDelayCode[0] + 9'd1)
      else $error("locked code jumped");
   lock_code_a: assert property (|lock |-> (!lock[0] || slaveDelayCode[0] != '0) && (!lock[1] || slaveDelayCode[1] != '0))
      else $error("lock with zero code");
   err_phase_a: assert property (pslverr |-> psel && penable)
      else $error("error outside access phase");
   unmapped_err_a: assert property (psel && penable && paddr == 8'h18 |-> pslverr && prdata == '0)
      else $error("unmapped access not refused");

   cover property ($rose(lock[0]));
   cover property ($rose(irq));
   cover property (pslverr);
endmodule

// file: verif/ref_source.sv
`timescale 1ns/1ps
module ref_source (
   output logic [1:0] pllRefClk,
   output logic [1:0] pinRefClk,
   output logic       strobeIn,
   output logic       clkIn
);
   initial begin
      pllRefClk = 2'h0;
      pinRefClk = 2'h0;
   end
   // free running, phase unrelated to sys_clk
   always #100.3 pllRefClk[0] = ~pllRefClk[0];
   always #120.7 pllRefClk[1] = ~pllRefClk[1];
   always #200.9 pinRefClk[0] = ~pinRefClk[0];
   always #160.1 pinRefClk[1] = ~pinRefClk[1];
   assign strobeIn = pllRefClk[0];
   assign clkIn = pinRefClk[1];
endmodule

// file: verif/test_master_dll_delay_code_gen.sv
`timescale 1ns/1ps
module test_master_dll_delay_code_gen
   import dll_pkg::*;
();
   typedef struct packed {logic [7:0] a; logic [31:0] d; logic e;} row_s;
   logic            sys_clk = 1'b0;
   logic            arst_n = 1'b0;
   logic            freeze = 1'b0;
   logic            codeUpdate_n = 1'b0;
   logic            psel = 1'b0;
   logic            penable = 1'b0;
   logic            pwrite = 1'b0;
   logic [7:0]      paddr = 8'h00;
   logic [31:0]     pwdata = 32'h0000_0000;
   logic [1:0]      pllRefClk, pinRefClk, lock;
   logic            strobeIn, clkIn, strobeShifted, clkShifted, irq, pready, pslverr, er;
   logic [31:0]     prdata, rd;
   logic [1:0][7:0] slaveDelayCode, userDelayCode;
   int              badCount = 0;
   int              checksDone = 0;
   row_s            rows [7] = '{'{CTRL_OFS, 32'h0000_0024, 1'b0}, '{STATUS_OFS, 32'h0000_0003, 1'b0},
      '{CODE_OFS, 32'h0000_100a, 1'b0}, '{USER_CODE_OFS, 32'h0000_100a, 1'b0},
      '{IRQ_STAT_OFS, 32'h0000_0003, 1'b0}, '{IRQ_MASK_OFS, 32'h0000_0000, 1'b0}, '{8'h18, 32'h0000_0000, 1'b1}};

   always #2.5 sys_clk = ~sys_clk;

   ref_source src (.pllRefClk(pllRefClk), .pinRefClk(pinRefClk), .strobeIn(strobeIn), .clkIn(clkIn));

   master_dll_delay_code_gen dut (.sys_clk(sys_clk), .arst_n(arst_n), .ce(1'b1), .pllRefClk(pllRefClk),
      .pinRefClk(pinRefClk), .freeze(freeze), .codeUpdate_n(codeUpdate_n), .strobeIn(strobeIn), .clkIn(clkIn),
      .strobeShifted(strobeShifted), .clkShifted(clkShifted), .slaveDelayCode(slaveDelayCode),
      .userDelayCode(userDelayCode), .lock(lock), .irq(irq), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr));

   task finish_test;
      if (badCount == 0 && checksDone > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checksDone++;
      if (g !== e) begin
         badCount++;
         $display("unexpected %s: expected %h seen %h", nm, e, g);
      end
   endtask

   task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge sys_clk);
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      psel <= 1'b1;
      penable <= 1'b0;
      @(posedge sys_clk);
      penable <= 1'b1;
      do begin
         @(posedge sys_clk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task wait_lock(input logic [1:0] m);
      int k;
      k = 0;
      while ((lock & m) !== m && k < 3000) begin
         @(posedge sys_clk);
         k++;
      end
      chk("lock", m, lock & m);
   endtask

   // cycles from input rise to shifted rise, one cycle of sync jitter and one of sampling
   task meas(input logic w, input int c);
      int k;
      k = 0;
      @(posedge (w ? clkIn : strobeIn));
      do begin
         @(posedge sys_clk);
         k++;
      end while ((w ? clkShifted : strobeShifted) !== 1'b1 && k < 300);
      chk("shift delay", 32'h0000_0001, k >= c && k <= c + 2);
   endtask

   initial begin
      int n;
      repeat (4) @(posedge sys_clk);
      arst_n <= 1'b1;
      apb(CTRL_OFS, 1'b1, 32'h0000_0024);
      wait_lock(2'b11);
      foreach (rows[i]) begin
         apb(rows[i].a, 1'b0, 32'h0000_0000);
         chk("read data", rows[i].d, rd);
         chk("slave error", rows[i].e, er);
         chk("ready", 32'h0000_0001, pready);
      end
      meas(1'b0, 10);
      meas(1'b1, 16);
      apb(IRQ_MASK_OFS, 1'b1, 32'h0000_0001);
      @(negedge sys_clk);
      chk("irq", 32'h0000_0001, irq);
      apb(IRQ_STAT_OFS, 1'b1, 32'h0000_0001);
      @(negedge sys_clk);
      chk("irq", 32'h0000_0000, irq);
      apb(IRQ_STAT_OFS, 1'b0, 32'h0000_0000);
      chk("irq status", 32'h0000_0002, rd);
      codeUpdate_n <= 1'b1;
      freeze <= 1'b1;
      apb(CTRL_OFS, 1'b1, 32'h0000_0026);
      repeat (600) @(posedge sys_clk);
      apb(STATUS_OFS, 1'b0, 32'h0000_0000);
      chk("status", 32'h0000_0103, rd);
      chk("frozen code", 32'h0000_100a, slaveDelayCode);
      freeze <= 1'b0;
      n = 0;
      while (slaveDelayCode[0] !== 8'h14 && n < 3000) begin
         @(posedge sys_clk);
         n++;
      end
      chk("code", 32'h0000_0014, slaveDelayCode[0]);
      chk("held user", 32'h0000_100a, userDelayCode);
      codeUpdate_n <= 1'b0;
      repeat (200) @(posedge sys_clk);
      chk("user code", 32'h0000_1014, userDelayCode);
      arst_n <= 1'b0;
      @(negedge sys_clk);
      chk("lock", 32'h0000_0000, lock);
      chk("code", 32'h0000_0000, slaveDelayCode);
      chk("user code", 32'h0000_0000, userDelayCode);
      repeat (4) @(posedge sys_clk);
      arst_n <= 1'b1;
      apb(CTRL_OFS, 1'b0, 32'h0000_0000);
      chk("ctrl", 32'h0000_0000, rd);
      wait_lock(2'b11);
      chk("code", 32'h0000_0c0a, slaveDelayCode);
      finish_test();
   end

   initial begin
      repeat (20000) @(posedge sys_clk);
      badCount++;
      finish_test();
   end
endmodule

bind master_dll_delay_code_gen dll_code_checker #(.NUM_LOOPS(NUM_LOOPS), .CODE_W(CODE_W)) mon (
   .sys_clk(sys_clk), .arst_n(arst_n), .freeze(freeze), .codeUpdate_n(codeUpdate_n),
   .slaveDelayCode(slaveDelayCode), .userDelayCode(userDelayCode), .lock(lock), .irq(irq),
   .paddr(paddr), .psel(psel), .penable(penable), .prdata(prdata), .pslverr(pslverr));
